// ===== design/eebl_map.svh
// Purpose: offsets, field positions, reset values and timing of the boot loader
// Assumes: register index times four is the Wishbone byte address
// Notes:   definitions only
`ifndef EEBL_MAP_SVH
`define EEBL_MAP_SVH
// ****************************************
// image layout
// ****************************************
`define EEBL_MARKER    8'hc4
`define EEBL_DEFLEN    16'h0006
`define EEBL_MAXLEN    16'h01f4
`define EEBL_DBASE     10'h006
`define EEBL_CTRL_HI   4'ha
// ****************************************
// register indices
// ****************************************
`define EEBL_IDX_IFCFG 8'h01
`define EEBL_IDX_POLAR 8'h04
`define EEBL_IDX_STAT  8'h08
`define EEBL_IDX_ISTAT 8'h09
`define EEBL_IDX_ICLR  8'h0a
`define EEBL_IDX_IEN   8'h0b
`define EEBL_IDX_LEN   8'h0c
`define EEBL_IDX_VID   8'h0d
`define EEBL_IDX_PID   8'h0e
`define EEBL_IDX_DID   8'h0f
`define EEBL_IDX_PTR   8'h10
`define EEBL_IDX_DATA  8'h11
`define EEBL_IDX_HDESC 8'h30
// ****************************************
// reset values and interrupt bits
// ****************************************
`define EEBL_IFCFG_RST 8'h00
`define EEBL_POLAR_RST 8'h00
`define EEBL_IRQ_READY 0
`define EEBL_IRQ_ENUM  2
// ****************************************
// timing
// ****************************************
`define EEBL_CLK_NS    8
`define EEBL_SCL_NS    160
`define EEBL_QTR       ((`EEBL_SCL_NS) / (4 * `EEBL_CLK_NS))
`endif

// ===== design/eebl_pkg.sv
// Purpose: types shared by the boot loader and its serial engine
// Assumes: nothing
// Notes:   constants live in eebl_map.svh
package eebl_pkg;
    typedef enum logic [1:0] {EEBL_OP_START, EEBL_OP_WR, EEBL_OP_RD, EEBL_OP_STOP} eebl_op_type;
    typedef struct packed {
        logic        go;
        eebl_op_type op;
        logic [7:0]  wdata;
        logic        nack;
    } eebl_cmd_type;
    typedef struct packed {
        logic       done;
        logic [7:0] rdata;
        logic       ack;
    } eebl_rsp_type;
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } eebl_pin_type;
    typedef enum {PH_IDLE, PH_START, PH_BIT, PH_STOP} eebl_ph_type;
    typedef enum {ST_CATCH, ST_PSTART, ST_PCTRL, ST_ADRH, ST_ADRL, ST_RSTART, ST_RCTRL,
                  ST_READ, ST_DUMMY, ST_STOP, ST_DONE, ST_WAITM, ST_UP} eebl_st_type;
endpackage

// ===== design/eebl_i2c_phy.sv
// Purpose: byte level two-wire master: start, write, read, stop
// Assumes: pull-ups on both wires; no clock stretching by the memory
// Notes:   bus clock made by dividing mclk into quarter periods
`timescale 1ns/1ps
`include "eebl_map.svh"
module eebl_i2c_phy
    import eebl_pkg::*;
(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         arst_n,
    // command and answer
    input  wire eebl_cmd_type cmd,
    output eebl_rsp_type      rsp,
    // wires
    input  wire logic         sda_i,
    output eebl_pin_type      pin
);
    typedef struct packed {
        eebl_ph_type ph;
        logic [2:0]  cnt;
        logic [1:0]  qtr;
        logic [3:0]  bitn;
        logic [8:0]  sh;
        logic        scl_oe;
        logic        sda_oe;
        logic        s1;
        logic        s2;
        eebl_rsp_type rsp;
    } eebl_phy_type;
    eebl_phy_type r;
    eebl_phy_type n;
    logic         tick;
    // ****************************************
    // sequencing of quarter periods
    // ****************************************
    always_comb begin
        n = r;
        n.rsp.done = 1'b0;
        n.s1 = sda_i;
        n.s2 = r.s1;
        tick = (r.cnt == 3'(`EEBL_QTR - 1));
        if (r.ph != PH_IDLE) begin
            n.cnt = tick ? 3'h0 : 3'(r.cnt + 3'h1);
            if (tick) n.qtr = 2'(r.qtr + 2'h1);
        end
        case (r.ph)
            PH_IDLE: if (cmd.go) begin
                n.cnt = 3'h0;
                n.qtr = 2'h0;
                n.bitn = 4'h0;
                n.sh = (cmd.op == EEBL_OP_RD) ? {8'hff, cmd.nack} : {cmd.wdata, 1'b1};
                case (cmd.op)
                    EEBL_OP_START: begin n.ph = PH_START; n.sda_oe = 1'b0; end
                    EEBL_OP_STOP:  begin n.ph = PH_STOP;  n.sda_oe = 1'b1; end
                    default:       begin n.ph = PH_BIT;   n.sda_oe = ~n.sh[8]; end
                endcase
            end
            // sda falls only while scl is released, so a repeated start works too
            PH_START: if (tick) begin
                case (r.qtr)
                    2'h0: n.scl_oe = 1'b0;
                    2'h1: n.sda_oe = 1'b1;
                    2'h2: n.scl_oe = 1'b1;
                    default: begin n.ph = PH_IDLE; n.rsp.done = 1'b1; end
                endcase
            end
            PH_BIT: if (tick) begin
                case (r.qtr)
                    2'h0: n.scl_oe = 1'b0;
                    2'h1: n.sh = {r.sh[7:0], r.s2}; // sample mid high phase
                    2'h2: n.scl_oe = 1'b1;
                    default: if (r.bitn == 4'h8) begin
                        n.ph = PH_IDLE;
                        n.rsp = '{done: 1'b1, rdata: r.sh[8:1], ack: ~r.sh[0]};
                    end else begin
                        n.bitn = 4'(r.bitn + 4'h1);
                        n.sda_oe = ~r.sh[8];
                    end
                endcase
            end
            PH_STOP: if (tick) begin
                case (r.qtr)
                    2'h0: n.scl_oe = 1'b0;
                    2'h1: n.sda_oe = 1'b0;
                    2'h2: ;
                    default: begin n.ph = PH_IDLE; n.rsp.done = 1'b1; end
                endcase
            end
            default: n.ph = PH_IDLE;
        endcase
    end
    // state register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) r <= '{ph: PH_IDLE, default: '0};
        else r <= n;
    end
    assign rsp = r.rsp;
    assign pin = '{scl_o: 1'b0, scl_oe: r.scl_oe, sda_o: 1'b0, sda_oe: r.sda_oe};
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_done_single: assert property (rsp.done |=> !rsp.done) else $error("done longer than one cycle");
    a_sda_scl_high: assert property ($changed(r.sda_oe) && r.ph == PH_BIT |-> r.scl_oe)
        else $error("sda moved while scl high");
endmodule // eebl_i2c_phy

// ===== design/eebl_boot_loader.sv
// Purpose: probe the serial memory at power-up, load settings and descriptor
// Assumes: set_config comes from logic on mclk; straps and sda are pins
// Notes:   registers on classic Wishbone, one aligned word per register index
`timescale 1ns/1ps
`include "eebl_map.svh"
module eebl_boot_loader
    import eebl_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // serial memory wires
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic [2:0]  eeprom_addr_strap,
    // usb core side
    input  wire logic        set_config,
    output logic             usb_attach,
    output logic             default_enum,
    // interrupt
    output logic             irq
);
    typedef struct packed {
        eebl_st_type  st;
        logic         pend;
        eebl_cmd_type cmd;
        logic [2:0]   s1;
        logic [2:0]   s2;
        logic [2:0]   strap;
        logic [9:0]   idx;
        logic [15:0]  len;
        logic         present;
        logic         hdr_ok;
        logic         desc_ok;
        logic         err;
        logic [7:0]   ifcfg;
        logic [7:0]   polar;
        logic [15:0]  vid;
        logic [15:0]  pid;
        logic [15:0]  device_release_id;
        logic [7:0]   istat;
        logic [7:0]   ien;
        logic [8:0]   ptr;
        logic [9:0]   hcnt;
        logic         attach;
        logic         dflt;
        logic         irq;
        logic         ack;
        logic [31:0]  dat;
    } eebl_ctl_type;
    eebl_ctl_type r;
    eebl_ctl_type n;
    eebl_rsp_type rsp;
    eebl_pin_type pin;
    logic [7:0]   mem [0:499];
    logic         mw;
    logic [8:0]   ma;
    logic [7:0]   md;
    logic [7:0]   b;
    logic [7:0]   ri;
    logic [7:0]   clr;
    logic [7:0]   set;
    logic [15:0]  full;
    logic         acc;
    logic         fin;
    logic         fail;
    // ****************************************
    // serial engine
    // ****************************************
    eebl_i2c_phy u_phy (
        .mclk   (mclk),
        .arst_n (arst_n),
        .cmd    (r.cmd),
        .rsp    (rsp),
        .sda_i  (sda_i),
        .pin    (pin)
    );
    // ****************************************
    // boot sequencer and register file
    // ****************************************
    always_comb begin
        n = r;
        n.cmd.go = 1'b0;
        n.s1 = eeprom_addr_strap;
        n.s2 = r.s1;
        mw = 1'b0;
        ma = 9'h000;
        md = 8'h00;
        b = rsp.rdata;
        clr = 8'h00;
        set = 8'h00;
        fail = 1'b0;
        full = {b, r.len[7:0]};
        fin = (r.idx >= `EEBL_DBASE) && ({6'h00, r.idx} == 16'(r.len + 16'h0005));
        // operation for the current sequencer step
        case (r.st)
            ST_PSTART, ST_RSTART: n.cmd.op = EEBL_OP_START;
            ST_PCTRL: n.cmd = '{1'b0, EEBL_OP_WR, {`EEBL_CTRL_HI, r.strap, 1'b0}, 1'b0};
            ST_RCTRL: n.cmd = '{1'b0, EEBL_OP_WR, {`EEBL_CTRL_HI, r.strap, 1'b1}, 1'b0};
            ST_ADRH, ST_ADRL: n.cmd = '{1'b0, EEBL_OP_WR, 8'h00, 1'b0}; // start at zero
            ST_READ: n.cmd = '{1'b0, EEBL_OP_RD, 8'h00, fin}; // last byte gets no ack
            ST_DUMMY: n.cmd = '{1'b0, EEBL_OP_RD, 8'h00, 1'b1};
            ST_STOP: n.cmd.op = EEBL_OP_STOP;
            default: ;
        endcase
        case (r.st)
            // strap is caught after release, once through the synchroniser
            ST_CATCH: begin
                n.idx = 10'(r.idx + 10'h001);
                if (r.idx == 10'h003) begin
                    n.strap = r.s2;
                    n.idx = 10'h000;
                    n.st = ST_PSTART;
                end
            end
            ST_DONE: begin
                if (r.desc_ok) begin
                    n.attach = 1'b1;
                    n.dflt = (r.len == `EEBL_DEFLEN);
                    n.st = ST_UP;
                end else begin
                    set[`EEBL_IRQ_READY] = r.ien[`EEBL_IRQ_READY];
                    n.st = ST_WAITM;
                end
            end
            ST_WAITM, ST_UP: ;
            default: begin
                if (!r.pend) begin
                    n.cmd.go = 1'b1;
                    n.pend = 1'b1;
                end else if (rsp.done) begin
                    n.pend = 1'b0;
                    case (r.st)
                        ST_PSTART: n.st = ST_PCTRL;
                        ST_PCTRL: begin
                            n.present = rsp.ack;
                            // two address bytes only when strap bit 0 is set
                            n.st = !rsp.ack ? ST_STOP : (r.strap[0] ? ST_ADRH : ST_ADRL);
                        end
                        ST_ADRH: n.st = ST_ADRL;
                        ST_ADRL: n.st = ST_RSTART;
                        ST_RSTART: n.st = ST_RCTRL;
                        ST_RCTRL: begin
                            n.err = !rsp.ack;
                            n.st = rsp.ack ? ST_READ : ST_STOP;
                        end
                        ST_READ: begin
                            n.idx = 10'(r.idx + 10'h001);
                            case (r.idx)
                                10'h000: begin
                                    fail = (b != `EEBL_MARKER);
                                    n.hdr_ok = !fail;
                                end
                                10'h001: n.ifcfg = b;
                                10'h002: n.polar = b;
                                10'h003: fail = (b != `EEBL_MARKER);
                                10'h004: n.len[7:0] = b;
                                10'h005: begin
                                    n.len = full;
                                    fail = (full == 16'h0000) || (full > `EEBL_MAXLEN);
                                    n.err = fail;
                                end
                                default: begin
                                    mw = 1'b1;
                                    ma = 9'(r.idx - `EEBL_DBASE);
                                end
                            endcase
                            md = b;
                            if (r.len == `EEBL_DEFLEN) begin
                                case (r.idx)
                                    10'h006: n.vid[7:0] = b;
                                    10'h007: n.vid[15:8] = b;
                                    10'h008: n.pid[7:0] = b;
                                    10'h009: n.pid[15:8] = b;
                                    10'h00a: n.device_release_id[7:0] = b;
                                    10'h00b: n.device_release_id[15:8] = b;
                                    default: ;
                                endcase
                            end
                            if (fail) n.st = ST_DUMMY;
                            else if (fin) begin
                                n.desc_ok = 1'b1;
                                n.st = ST_STOP;
                            end
                        end
                        ST_DUMMY: n.st = ST_STOP;
                        default: n.st = ST_DONE;
                    endcase
                end
            end
        endcase
        // wishbone: one wait state, ack drops the cycle after
        acc = wb_cyc_i && wb_stb_i && !r.ack;
        ri = wb_adr_i[9:2];
        n.ack = acc;
        n.dat = 32'h0000_0000;
        if (acc && wb_adr_i[31:10] == 22'h000000) begin
            if (wb_we_i && wb_sel_i[0]) begin
                if (ri == `EEBL_IDX_IFCFG) n.ifcfg = wb_dat_i[7:0];
                else if (ri == `EEBL_IDX_POLAR) n.polar = wb_dat_i[7:0];
                else if (ri == `EEBL_IDX_ICLR) clr = wb_dat_i[7:0];
                else if (ri == `EEBL_IDX_IEN) n.ien = wb_dat_i[7:0];
                else if (ri == `EEBL_IDX_PTR) n.ptr = {1'b0, wb_dat_i[7:0]};
                else if (ri == `EEBL_IDX_HDESC && r.st == ST_WAITM) begin
                    // master streams length low, length high, then descriptor bytes
                    n.hcnt = 10'(r.hcnt + 10'h001);
                    if (r.hcnt == 10'h000) n.len[7:0] = wb_dat_i[7:0];
                    else if (r.hcnt == 10'h001) begin
                        n.len = {wb_dat_i[7:0], r.len[7:0]};
                        if (n.len == 16'h0000 || n.len > `EEBL_MAXLEN) begin
                            n.err = 1'b1;
                            n.hcnt = 10'h000;
                        end
                    end else begin
                        mw = 1'b1;
                        ma = 9'(r.hcnt - 10'h002);
                        md = wb_dat_i[7:0];
                        if (r.len == `EEBL_DEFLEN) begin
                            case (r.hcnt)
                                10'h002: n.vid[7:0] = md;
                                10'h003: n.vid[15:8] = md;
                                10'h004: n.pid[7:0] = md;
                                10'h005: n.pid[15:8] = md;
                                10'h006: n.device_release_id[7:0] = md;
                                10'h007: n.device_release_id[15:8] = md;
                                default: ;
                            endcase
                        end
                        if ({6'h00, r.hcnt} == 16'(r.len + 16'h0001)) begin
                            n.attach = 1'b1;
                            n.dflt = (r.len == `EEBL_DEFLEN);
                            n.st = ST_UP;
                        end
                    end
                end
            end else if (!wb_we_i) begin
                if (ri == `EEBL_IDX_IFCFG) n.dat = {24'h0, r.ifcfg};
                else if (ri == `EEBL_IDX_POLAR) n.dat = {24'h0, r.polar};
                else if (ri == `EEBL_IDX_STAT)
                    n.dat = {25'h0, r.attach, r.st == ST_WAITM, r.err, r.dflt, r.desc_ok, r.hdr_ok, r.present};
                else if (ri == `EEBL_IDX_ISTAT) n.dat = {24'h0, r.istat};
                else if (ri == `EEBL_IDX_IEN) n.dat = {24'h0, r.ien};
                else if (ri == `EEBL_IDX_LEN) n.dat = {16'h0, r.len};
                else if (ri == `EEBL_IDX_VID) n.dat = {16'h0, r.vid};
                else if (ri == `EEBL_IDX_PID) n.dat = {16'h0, r.pid};
                else if (ri == `EEBL_IDX_DID) n.dat = {16'h0, r.device_release_id};
                else if (ri == `EEBL_IDX_PTR) n.dat = {23'h0, r.ptr};
                else if (ri == `EEBL_IDX_DATA) begin
                    // reading data steps the pointer; beyond the array reads zero
                    n.dat = (r.ptr < 9'h1f4) ? {24'h0, mem[r.ptr]} : 32'h0;
                    n.ptr = 9'(r.ptr + 9'h001);
                end
            end
        end
        // host configures the attached device
        if (set_config && r.attach) set[`EEBL_IRQ_ENUM] = r.ien[`EEBL_IRQ_ENUM];
        n.istat = (r.istat & ~clr) | set; // set wins over a same-cycle clear
        n.irq = |(n.istat & n.ien);
    end
    // state register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) r <= '{st: ST_CATCH, cmd: '{1'b0, EEBL_OP_START, 8'h00, 1'b0},
                            ifcfg: `EEBL_IFCFG_RST, polar: `EEBL_POLAR_RST, default: '0};
        else r <= n;
    end
    // descriptor store, no reset needed
    always_ff @(posedge mclk) begin
        if (mw && ma < 9'h1f4) mem[ma] <= md;
    end
    assign wb_dat_o = r.dat;
    assign wb_ack_o = r.ack;
    assign usb_attach = r.attach;
    assign default_enum = r.dflt;
    assign irq = r.irq;
    assign {scl_o, scl_oe, sda_o, sda_oe} = pin;
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_done(logic [9:0] i);
        r.st == ST_READ && r.pend && rsp.done && r.idx == i;
    endsequence
    a_wb_answer: assert property (s_wb_req |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack timing");
    a_if_load: assert property (s_rd_done(10'h001) |=> r.ifcfg == $past(rsp.rdata))
        else $error("interface_config not loaded");
    a_polar_load: assert property (s_rd_done(10'h002) |=> r.polar == $past(rsp.rdata))
        else $error("flag_polarity not loaded");
    a_len_low: assert property (s_rd_done(10'h004) |=> r.len[7:0] == $past(rsp.rdata))
        else $error("length low byte not loaded");
    a_len_order: assert property (s_rd_done(10'h005) |=> r.len == {$past(rsp.rdata), $past(r.len[7:0])})
        else $error("length byte order");
    a_len_limit: assert property (r.desc_ok |-> r.len <= `EEBL_MAXLEN) else $error("length over limit");
    a_attach_cause: assert property ($rose(usb_attach) |->
        $past(r.st == ST_WAITM || (r.st == ST_DONE && r.desc_ok))) else $error("attach too early");
    a_no_ready: assert property (r.desc_ok |-> !r.istat[`EEBL_IRQ_READY]) else $error("ready on valid boot");
    a_enum_irq: assert property (set_config && usb_attach && r.ien[`EEBL_IRQ_ENUM] |=>
        r.istat[`EEBL_IRQ_ENUM] && irq) else $error("enumeration irq missing");
    a_probe_nack: assert property (r.st == ST_PCTRL && r.pend && rsp.done && !rsp.ack |=>
        !r.present && r.st == ST_STOP) else $error("absent memory not seen");
endmodule // eebl_boot_loader

// ===== bench/eebl_mem_model.sv
// Purpose: behavioural serial memory on the two boot wires
// Assumes: pull-ups on both wires, levels worked out by the bench
// Notes:   bench fills mem; bad marks a wrong count of address bytes
`timescale 1ns/1ps
module eebl_mem_model (
    // wires
    input  wire logic scl,
    input  wire logic sda,
    // setup
    input  wire logic present,
    input  wire logic two,
    // answer
    output logic      sda_pull,
    output logic      bad
);
    logic [7:0] mem [0:511];
    logic [7:0] sh;
    logic [9:0] ptr;
    logic       act, rd, dat, first;
    int         bc, na;
    initial begin
        sda_pull = 0;
        bad = 0;
        act = 0;
    end
    // start or repeated start: sda falls while scl high
    always @(negedge sda) if (scl) begin
        // a repeated start must follow exactly the address bytes this part expects
        if (act && !first && na != (two ? 2 : 1)) bad = 1;
        act = present;
        bc = -1;
        first = 1;
        rd = 0;
        dat = 0;
        na = 0;
    end
    always @(posedge sda) if (scl) act = 0;
    // sample on rising scl; a nack from the master ends a read
    always @(posedge scl) if (act) begin
        if (bc < 8) sh = {sh[6:0], sda};
        else if (dat) begin
            ptr = ptr + 10'h001;
            if (sda) act = 0;
        end
    end
    // drive on falling scl; a released wire floats high
    always @(negedge scl) if (act) begin
        bc = (bc == 8) ? 0 : bc + 1;
        if (bc == 8 && !dat) begin
            if (first) rd = sh[0];
            else if (na < (two ? 2 : 1)) begin
                ptr = (na == 0) ? {2'b00, sh} : {ptr[1:0], sh};
                na++;
            end else bad = 1; // single-byte part would store this
            first = 0;
            sda_pull = 1;
        end else if (rd && bc < 8) begin
            dat = 1;
            sda_pull = !mem[ptr][7 - bc];
        end else sda_pull = 0;
    end
endmodule // eebl_mem_model

// ===== bench/test_eebl_boot_loader.sv
// Purpose: boot from memory, from master, and with a bad marker
// Assumes: wishbone ack exactly one cycle after the taken edge
// Notes:   register contents compared through the bus
`timescale 1ns/1ps
module test_eebl_boot_loader;
    logic        mclk, arst_n, cyc, stb, we, set_config, present;
    logic        ack, sda_oe, scl_oe, pull, bad, attach, denum, irq;
    logic [31:0] adr, wdat, rdat, q;
    logic [2:0]  strap;
    wire logic   scl_w = !scl_oe;
    wire logic   sda_w = !(sda_oe | pull);
    int          n_fail = 0;
    int          tests_run = 0;
    eebl_boot_loader DUT (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .scl_o(), .scl_oe(scl_oe), .eeprom_addr_strap(strap),
        .set_config(set_config), .usb_attach(attach), .default_enum(denum), .irq(irq));
    eebl_mem_model mem_m (.scl(scl_w), .sda(sda_w), .present(present), .two(strap[0]),
        .sda_pull(pull), .bad(bad));
    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic cycle; ack and read data taken at the same edge
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge mclk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {22'h0, idx, 2'h0};
        wdat <= {24'h0, d};
        @(posedge mclk iff ack === 1'b1);
        q = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
        wb(0, idx, 8'h00);
        chk(nm, q, e);
    endtask
    task automatic load(input logic [7:0] b [12]);
        for (int i = 0; i < 12; i++) mem_m.mem[i] = b[i];
    endtask
    task automatic pulse;
        @(posedge mclk);
        set_config <= 1;
        @(posedge mclk);
        set_config <= 0;
        repeat (2) @(posedge mclk);
    endtask
    // reset, enable both interrupts, poll until attached or waiting
    task automatic boot(input logic p, input logic [2:0] s);
        int n;
        arst_n <= 0;
        present <= p;
        strap <= s;
        repeat (3) @(posedge mclk);
        arst_n <= 1;
        wb(1, 8'h0b, 8'h05);
        n = 0;
        do begin
            wb(0, 8'h08, 8'h00);
            n++;
        end while (q[6:5] == 2'b00 && n < 4000);
        chk("boot_done", n < 4000, 1);
    endtask
    task automatic t_default;
        load('{8'hc4, 8'h5a, 8'h3c, 8'hc4, 8'h06, 8'h00, 8'h47, 8'h05, 8'h02, 8'h10, 8'h01, 8'h00});
        boot(1, 3'b000);
        chk("status", q[6:0], 7'h4f);
        chk("attach", attach, 1);
        chk("default_enum", denum, 1);
        chk("addr_bytes", bad, 0);
        rdc("interface_config", 8'h01, 32'h5a);
        rdc("flag_polarity", 8'h04, 32'h3c);
        rdc("len", 8'h0c, 32'h0006);
        rdc("vid", 8'h0d, 32'h0547);
        rdc("pid", 8'h0e, 32'h1002);
        rdc("did", 8'h0f, 32'h0001);
        rdc("no_ready", 8'h09, 32'h0);
        rdc("unmapped", 8'h20, 32'h0);
        pulse;
        chk("irq", irq, 1);
        rdc("int_status", 8'h09, 32'h4);
        wb(1, 8'h0a, 8'h04);
        rdc("cleared", 8'h09, 32'h0);
        chk("irq_off", irq, 0);
    endtask
    // no memory: master streams length six then the ids
    task automatic t_master;
        logic [7:0] v [8] = '{8'h06, 8'h00, 8'h47, 8'h05, 8'h02, 8'h10, 8'h01, 8'h00};
        boot(0, 3'b000);
        chk("status", q[6:0], 7'h20);
        rdc("ready", 8'h09, 32'h1);
        chk("irq", irq, 1);
        wb(1, 8'h30, 8'hf5);
        wb(1, 8'h30, 8'h01);
        rdc("len_limit", 8'h08, 32'h30);
        for (int i = 0; i < 8; i++) begin
            if (i == 7) chk("early_attach", attach, 0);
            wb(1, 8'h30, v[i]);
        end
        repeat (2) @(posedge mclk);
        chk("attach", attach, 1);
        chk("default_enum", denum, 1);
        rdc("vid", 8'h0d, 32'h0547);
    endtask
    task automatic t_badmark;
        load('{8'hc4, 8'ha5, 8'h96, 8'h11, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        boot(1, 3'b001);
        chk("status", q[6:0], 7'h23);
        chk("attach", attach, 0);
        chk("addr_bytes", bad, 0);
        rdc("interface_config", 8'h01, 32'ha5);
        rdc("flag_polarity", 8'h04, 32'h96);
        pulse;
        rdc("no_enum", 8'h09, 32'h1);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #240000;
        n_fail++;
        finish_test;
    end
    initial begin
        {cyc, stb, we, set_config, present, arst_n} = 6'h00;
        {adr, wdat, strap} = 67'h0;
        t_default;
        t_master;
        t_badmark;
        finish_test;
    end
endmodule // test_eebl_boot_loader
